// file: rtl/mre_consts.vh
`ifndef MRE_CONSTS_VH
`define MRE_CONSTS_VH
// Summary of operation
// [R01] register clock: global, enabled global, or array
// [R02] enabled mode captures only while enable high
// [R03] array clock is a product term
// [R04] two clock nets, true/inverted of either pin
// [R05] small variant: one net from pin one
// [R06] product-term preset and clear, high active
// [R07] low-active control inverted inside the array
// [R08] per-register clear from global clear pin low
// [R09] all registers zero at power-up
// [R10] fast input path from io pin to register
// [R11] five dedicated product terms per macrocell
// [R12] expanders feed macrocells in the same block
// [R13] at most three borrowed sets of five
// [R14] sixteen macrocells per logic array block
// [R15] two independent expander chains of eight
// [R16] borrow only from contiguous lower neighbours
// [R17] chain bottom only lends, top only borrows
// [R18] routing bus fed by inputs, pins, macrocells
// [R19] clear wins over preset
// [R20] d-type register, sum or fast input
// ===========================================
// sizes
`define MRE_N_MC 16
`define MRE_N_IO 12
`define MRE_N_DED 4
`define MRE_BUS_W 32
`define MRE_CHAIN 8
`define MRE_PT_PER_MC 9
`define MRE_N_PT 144
`define MRE_CFG_W 24
// ===========================================
// product term slots within a macrocell
`define MRE_PT_PRE 5
`define MRE_PT_CLR 6
`define MRE_PT_CLK 7
`define MRE_PT_ENA 8
// ===========================================
// register map, byte addresses and region selects
`define MRE_OFS_GCLK 12'h000
`define MRE_OFS_STAT 12'h004
`define MRE_OFS_BUS 12'h008
`define MRE_SEL_CFG 6'h04
`define MRE_SEL_TRUE 2'h1
`define MRE_SEL_COMP 2'h2
// ===========================================
// clock net register fields and reset value
`define MRE_GC_N0_PIN 0
`define MRE_GC_N0_INV 1
`define MRE_GC_N1_PIN 2
`define MRE_GC_N1_INV 3
`define MRE_GCLK_RST 4'h4
// ===========================================
// macrocell config fields and reset value
`define MRE_CF_MODE 1:0
`define MRE_CF_NET 2
`define MRE_CF_PRE 3
`define MRE_CF_CLR 4
`define MRE_CF_GCLR 5
`define MRE_CF_FAST 6
`define MRE_CF_BOR 8:7
`define MRE_CF_USE 14:10
`define MRE_CF_LEND 19:15
`define MRE_CF_FIDX 23:20
`define MRE_CFG_RST 24'h000000
`define MRE_MODE_GLB 2'h0
`define MRE_MODE_ENA 2'h1
`define MRE_MODE_ARR 2'h2
`endif

// file: rtl/mre_lab.v
`timescale 1ns/10ps
`include "mre_consts.vh"
// ===========================================
// logic array block: sixteen macrocells, their
// product terms, expander chains and clock nets,
// configured over a classic wishbone slave
module mre_lab #(
  parameter DUAL_NETS = 1
) (
  input wire clk_i,
  input wire reset_n_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire global_clock_pin_one_i,
  input wire global_clock_pin_two_i,
  input wire global_clear_pin_low_i,
  input wire [`MRE_N_DED-1:0] ded_in_i,
  input wire [`MRE_N_IO-1:0] io_in_i,
  output wire [`MRE_N_MC-1:0] mc_q_o
);

  // ===========================================
  // behaviour notes
  // register map, byte addresses:
  //   000 clock nets, 004 register status, 008 routing bus image
  //   100 + 4*m macrocell config, one word per macrocell
  //   400 + 4*p true literal mask, 800 + 4*p complement mask
  // limitation: pins are sampled as levels, so a net edge is
  // seen one system clock after the pin moves
  // limitation: preset and clear act at the next system edge,
  // since a truly async path would race the sampled pins
  // trade-off: masks reset to zero, so every term starts as an
  // empty one reading high; no control enable is set at reset,
  // so those high terms do nothing until software asks
  // mode three parks a cell: it never captures
  // config bit nine is spare and reads back as written

  // ===========================================
  // reset release
  reg rst_meta_reg;
  reg rst_n_reg;

  // assert at once, release after two edges
  // a bare release could free flops on different edges
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ===========================================
  // configuration storage
  reg [3:0] gclk_reg;
  reg [`MRE_CFG_W-1:0] cfg_mem [0:`MRE_N_MC-1];
  reg [`MRE_BUS_W-1:0] true_mem [0:`MRE_N_PT-1];
  reg [`MRE_BUS_W-1:0] comp_mem [0:`MRE_N_PT-1];

  wire [`MRE_N_MC-1:0] mc_q;
  wire [`MRE_BUS_W-1:0] rbus;
  wire [`MRE_N_PT-1:0] pt;

  // ===========================================
  // global routing bus
  // every dedicated input, pin and macrocell drives it
  // macrocells on top, pins in the middle, dedicated inputs at bit zero
  assign rbus = {mc_q, io_in_i, ded_in_i}; // R18
  assign mc_q_o = mc_q;

  // ===========================================
  // wishbone decode
  // ack low gates a held request so it is taken once
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i;
  wire [7:0] pt_idx = wb_adr_i[9:2];
  wire [3:0] cfg_idx = wb_adr_i[5:2];
  wire pt_ok = (pt_idx < `MRE_N_PT);
  // region selects; an index past the last term falls
  // through to unmapped, so it reads zero and ignores writes
  wire hit_gclk = (wb_adr_i == `MRE_OFS_GCLK);
  wire hit_stat = (wb_adr_i == `MRE_OFS_STAT);
  wire hit_bus = (wb_adr_i == `MRE_OFS_BUS);
  wire hit_cfg = (wb_adr_i[11:6] == `MRE_SEL_CFG);
  wire hit_true = (wb_adr_i[11:10] == `MRE_SEL_TRUE) & pt_ok;
  wire hit_comp = (wb_adr_i[11:10] == `MRE_SEL_COMP) & pt_ok;

  // byte-lane merge of a write into an old word
  function [31:0] mre_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] sel;
    integer b;
    begin
      mre_merge = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          mre_merge[b*8 +: 8] = new_v[b*8 +: 8];
        end
      end
    end
  endfunction

  wire [31:0] cfg_old = {8'h00, cfg_mem[cfg_idx]};
  wire [31:0] cfg_new = mre_merge(cfg_old, wb_dat_i, wb_sel_i);
  wire [31:0] gclk_new = mre_merge({28'h0000000, gclk_reg}, wb_dat_i, wb_sel_i);

  // ===========================================
  // configuration writes
  // arrays are cleared too, so no term starts unknown
  // a write with some lanes off keeps those bytes as they were
  integer i;
  always @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      gclk_reg <= `MRE_GCLK_RST;
      for (i = 0; i < `MRE_N_MC; i = i + 1) begin
        cfg_mem[i] <= `MRE_CFG_RST;
      end
      for (i = 0; i < `MRE_N_PT; i = i + 1) begin
        true_mem[i] <= 32'h00000000;
        comp_mem[i] <= 32'h00000000;
      end
    end else if (wr) begin
      if (hit_gclk) begin
        gclk_reg <= gclk_new[3:0];
      end
      if (hit_cfg) begin
        cfg_mem[cfg_idx] <= cfg_new[`MRE_CFG_W-1:0];
      end
      if (hit_true) begin
        true_mem[pt_idx] <= mre_merge(true_mem[pt_idx], wb_dat_i, wb_sel_i);
      end
      if (hit_comp) begin
        comp_mem[pt_idx] <= mre_merge(comp_mem[pt_idx], wb_dat_i, wb_sel_i);
      end
    end
  end

  // ===========================================
  // read mux; unmapped addresses read zero
  // status and bus images are live values, not latched ones
  reg [31:0] rd_next;
  always @* begin
    rd_next = 32'h00000000;
    if (hit_gclk) begin
      rd_next = {28'h0000000, gclk_reg};
    end else if (hit_stat) begin
      rd_next = {16'h0000, mc_q};
    end else if (hit_bus) begin
      rd_next = rbus;
    end else if (hit_cfg) begin
      rd_next = cfg_old;
    end else if (hit_true) begin
      rd_next = true_mem[pt_idx];
    end else if (hit_comp) begin
      rd_next = comp_mem[pt_idx];
    end
  end

  // one-cycle answer, ack dropped the cycle after
  // read data stays put until the next request is taken
  always @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= rd_next;
      end
    end
  end

  // ===========================================
  // global clock nets
  wire net0;
  wire net1;
  wire pin_a = gclk_reg[`MRE_GC_N0_PIN] ? global_clock_pin_two_i : global_clock_pin_one_i;
  wire pin_b = gclk_reg[`MRE_GC_N1_PIN] ? global_clock_pin_two_i : global_clock_pin_one_i;

  // inversion is an xor, so a net can follow a falling pin
  // small variant ties both nets to pin one, true
  generate
    if (DUAL_NETS) begin : g_dual
      assign net0 = pin_a ^ gclk_reg[`MRE_GC_N0_INV]; // R04
      assign net1 = pin_b ^ gclk_reg[`MRE_GC_N1_INV]; // R04
    end else begin : g_single
      assign net0 = global_clock_pin_one_i; // R05
      assign net1 = global_clock_pin_one_i; // R05
    end
  endgenerate

  // pins are synchronous, so edges come from one sample back
  // both edge flops start low, so a net high at reset counts one rise
  reg [1:0] net_prev_reg;
  always @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      net_prev_reg <= 2'b00;
    end else begin
      net_prev_reg <= {net1, net0};
    end
  end
  wire [1:0] net_rise = {net1, net0} & ~net_prev_reg;

  // ===========================================
  // all product terms, nine per macrocell
  // five logic slots, then preset, clear, array clock, enable
  genvar p;
  generate
    for (p = 0; p < `MRE_N_PT; p = p + 1) begin : g_pt
      mre_pterm #(
        .W(`MRE_BUS_W)
      ) u_pt (
        .bus_i(rbus),
        .true_mask_i(true_mem[p]),
        .comp_mask_i(comp_mem[p]),
        .term_o(pt[p])
      );
    end
  endgenerate

  // ===========================================
  // array clock edge memory
  // terms are levels here; the rise is found against last
  // cycle's copy, so a term held high clocks only once
  wire [`MRE_N_MC-1:0] clk_pt;
  reg [`MRE_N_MC-1:0] aclk_prev_reg;
  always @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      aclk_prev_reg <= {`MRE_N_MC{1'b0}};
    end else begin
      aclk_prev_reg <= clk_pt;
    end
  end

  // ===========================================
  // macrocells and expander chains
  // chain position is the index within its group of eight;
  // position zero sits at the bottom with no lender below,
  // the top position has its lend sum tied low
  // a borrow count of k takes the lend sums of the k cells just
  // below, which keeps lenders contiguous from the next neighbour
  wire [`MRE_N_MC-1:0] lend_sum;
  genvar m;
  genvar k;
  generate
    for (m = 0; m < `MRE_N_MC; m = m + 1) begin : g_mc // R14
      // per-cell slice of config and terms
      localparam integer POS = m % `MRE_CHAIN; // R15
      localparam integer B = m * `MRE_PT_PER_MC;
      wire [`MRE_CFG_W-1:0] cfg = cfg_mem[m];
      wire [4:0] lpt = pt[B +: 5];
      wire own_sum = |(lpt & cfg[`MRE_CF_USE]); // R11
      wire [2:0] near;
      reg [2:0] bor_mask;
      reg tick;
      wire d;
      wire pre;
      wire clr;
      wire [3:0] fidx = cfg[`MRE_CF_FIDX];
      wire net_hit;
      reg fast_bit;
      integer f;

      // top of a chain never lends
      if (POS == `MRE_CHAIN - 1) begin : g_top
        assign lend_sum[m] = 1'b0; // R17
      end else begin : g_lend
        assign lend_sum[m] = |(lpt & cfg[`MRE_CF_LEND]); // R13
      end

      // reach stops at the chain start, so the bottom only lends
      for (k = 1; k <= 3; k = k + 1) begin : g_near
        if (POS >= k) begin : g_in
          assign near[k-1] = lend_sum[m-k]; // R16
        end else begin : g_out
          assign near[k-1] = 1'b0; // R17
        end
      end

      // lenders are contiguous from the next lower neighbour
      always @* begin
        case (cfg[`MRE_CF_BOR])
          2'h1: bor_mask = 3'b001; // R16
          2'h2: bor_mask = 3'b011;
          2'h3: bor_mask = 3'b111; // R13
          default: bor_mask = 3'b000;
        endcase
      end

      // fast pin pick; an index past the last pin reads zero
      // rather than an out-of-range select
      always @* begin
        fast_bit = 1'b0;
        for (f = 0; f < `MRE_N_IO; f = f + 1) begin
          if (fidx == f) begin
            fast_bit = io_in_i[f]; // R10
          end
        end
      end

      // fast path skips routing bus and and-array
      assign d = cfg[`MRE_CF_FAST] ? fast_bit // R10
               : (own_sum | (|(near & bor_mask))); // R12
      assign clk_pt[m] = pt[B + `MRE_PT_CLK];

      // chosen net's edge; the small variant drives both nets alike
      assign net_hit = cfg[`MRE_CF_NET] ? net_rise[1] : net_rise[0];

      // capture strobe per clock mode
      always @* begin
        case (cfg[`MRE_CF_MODE]) // R01
          `MRE_MODE_GLB: tick = net_hit;
          `MRE_MODE_ENA: tick = net_hit & pt[B + `MRE_PT_ENA]; // R02
          `MRE_MODE_ARR: tick = clk_pt[m] & ~aclk_prev_reg[m]; // R03
          default: tick = 1'b0;
        endcase
      end

      // terms are high active; low-active control uses comp mask
      // the pin path is ored in per cell, so each cell opts in
      assign pre = cfg[`MRE_CF_PRE] & pt[B + `MRE_PT_PRE]; // R06
      assign clr = (cfg[`MRE_CF_CLR] & pt[B + `MRE_PT_CLR]) // R07
                 | (cfg[`MRE_CF_GCLR] & ~global_clear_pin_low_i); // R08

      mre_macrocell u_cell (
        .clk_i(clk_i),
        .rst_n_i(rst_n_reg),
        .tick_i(tick),
        .d_i(d),
        .pre_i(pre),
        .clr_i(clr),
        .q_o(mc_q[m])
      );
    end
  endgenerate

endmodule // mre_lab

// file: rtl/mre_macrocell.v
`timescale 1ns/10ps
// ===========================================
// macrocell d flip-flop with preset and clear
module mre_macrocell (
  input wire clk_i,
  input wire rst_n_i,
  input wire tick_i,
  input wire d_i,
  input wire pre_i,
  input wire clr_i,
  output reg q_o
);

  // clear checked first so it beats preset
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_o <= 1'b0; // R09
    end else if (clr_i) begin
      q_o <= 1'b0; // R19
    end else if (pre_i) begin
      q_o <= 1'b1; // R06
    end else if (tick_i) begin
      q_o <= d_i; // R20
    end
  end

endmodule // mre_macrocell

// file: rtl/mre_pterm.v
`timescale 1ns/10ps
// ===========================================
// one product term: and of chosen true and
// complemented routing bus literals
module mre_pterm #(
  parameter W = 32
) (
  input wire [W-1:0] bus_i,
  input wire [W-1:0] true_mask_i,
  input wire [W-1:0] comp_mask_i,
  output wire term_o
);

  // an empty term reads one, as in a real and-array
  assign term_o = (&(bus_i | ~true_mask_i)) & (&(~bus_i | ~comp_mask_i));

endmodule // mre_pterm

// file: verif/mre_lab_checker.sv
`timescale 1ns/10ps
// ===========================================
// port checks for the logic array block
module mre_lab_checker (
  input wire clk_i,
  input wire reset_n_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire global_clock_pin_one_i,
  input wire global_clock_pin_two_i,
  input wire global_clear_pin_low_i,
  input wire [3:0] ded_in_i,
  input wire [11:0] io_in_i,
  input wire [15:0] mc_q_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // bus answer timing: one edge after the request, one cycle wide
  a_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack not next cycle");
  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_has_request: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  // read data images, taken at the edge that took the request
  a_status_mirror: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 12'h004
    |-> wb_dat_o == {16'h0, $past(mc_q_o)}) else $error("status read wrong");
  a_bus_image: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 12'h008
    |-> wb_dat_o == {$past(mc_q_o), $past(io_in_i), $past(ded_in_i)}) else $error("routing bus read wrong");
  a_unmapped_zero: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 12'h00c
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_clkreg_upper: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 12'h000
    |-> wb_dat_o[31:4] == 28'h0) else $error("clock net read upper bits set");
  // registers still low at the first edge after reset lets go
  a_power_up_zero: assert property ($rose(reset_n_i) |-> mc_q_o == 16'h0) else $error("register not zero");
endmodule // mre_lab_checker

bind mre_lab mre_lab_checker i_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .global_clock_pin_one_i(global_clock_pin_one_i),
  .global_clock_pin_two_i(global_clock_pin_two_i), .global_clear_pin_low_i(global_clear_pin_low_i),
  .ded_in_i(ded_in_i), .io_in_i(io_in_i), .mc_q_o(mc_q_o));

// file: verif/mre_lab_tb.sv
`timescale 1ns/10ps
module mre_lab_tb;
  logic clk_i = 0, reset_n_i = 0, cyc = 0, we = 0, gp1 = 0, gp2 = 0, gclr_n = 1, wb_ack_o;
  logic [11:0] adr = 0, io = 0;
  logic [3:0] ded = 0;
  logic [31:0] wdat = 0, rd, wb_dat_o;
  logic [15:0] q, qs;
  int fail_count = 0, cmp_count = 0, tick = 0;
  mre_lab i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .global_clock_pin_one_i(gp1), .global_clock_pin_two_i(gp2), .global_clear_pin_low_i(gclr_n),
    .ded_in_i(ded), .io_in_i(io), .mc_q_o(q));
  // small variant on the same bus and pins; only its registers are read
  mre_lab #(.DUAL_NETS(0)) i_dut_single (.clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(),
    .wb_ack_o(), .global_clock_pin_one_i(gp1), .global_clock_pin_two_i(gp2),
    .global_clear_pin_low_i(gclr_n), .ded_in_i(ded), .io_in_i(io), .mc_q_o(qs));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // ===========================================
  // shared tasks
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task check(input string n, input [31:0] s, input [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // classic cycle; waits for ack, read data taken at that edge
  task wb(input w, input [11:0] a, input [31:0] d);
    @(posedge clk_i);
    cyc <= 1; we <= w; adr <= a; wdat <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 0; we <= 0;
  endtask
  task wt(int n);
    repeat (n) @(posedge clk_i);
  endtask
  // one pulse on clock pin one, then time for the capture to land
  task pin1;
    @(posedge clk_i); gp1 <= 1; wt(1); gp1 <= 0; wt(2);
  endtask
  // ===========================================
  // scenarios
  task t_reset;
    wb(0, 12'h000, 0); check("clock nets", rd, 32'h4);
    wb(0, 12'h004, 0); check("status", rd, 0);
    wb(0, 12'h100, 0); check("config", rd, 0);
    wb(0, 12'h00c, 0); check("unmapped", rd, 0);
    io <= 12'ha5c; ded <= 4'h9;
    wb(0, 12'h008, 0); check("routing bus", rd, {16'h0, 12'ha5c, 4'h9});
    $display("reset and bus test done");
  endtask
  task t_global;
    io <= 0; ded <= 0;
    wb(1, 12'h100, 32'h40); io <= 12'h001; pin1; check("global q0", q[0], 1);
    io <= 0; wt(3); check("hold q0", q[0], 1);
    wb(1, 12'h104, 32'h100041); wb(1, 12'h444, 32'h1); io <= 12'h002;
    pin1; check("enable low q1", q[1], 0);
    ded <= 4'h1; pin1; check("enable high q1", q[1], 1);
    $display("clock mode test done");
  endtask
  // inverted pin two on net 0: capture on the falling pin
  task t_invert;
    io <= 0; wb(1, 12'h000, 32'h7); wt(2);
    io <= 12'h001; gp2 <= 1; wt(3); check("pin two rise", q[0], 0);
    gp2 <= 0; wt(3); check("pin two fall", q[0], 1);
    check("single net q0", qs[0], 0);
    wb(1, 12'h000, 32'h4);
    $display("clock net test done");
  endtask
  // array clock from dedicated input 1
  task t_array;
    wb(1, 12'h108, 32'h200042); wb(1, 12'h464, 32'h2); io <= 12'h004;
    wt(3); check("array idle q2", q[2], 0);
    ded <= 4'h3; wt(3); check("array edge q2", q[2], 1);
    $display("array clock test done");
  endtask
  task t_prsclr;
    wb(1, 12'h10c, 32'h8); wt(3); check("preset q3", q[3], 1);
    wb(1, 12'h10c, 32'h18); wt(3); check("both q3", q[3], 0);
    wb(1, 12'h10c, 32'h28); wt(3); check("clear pin high", q[3], 1);
    gclr_n <= 0; wt(3); check("clear pin low", q[3], 0);
    gclr_n <= 1; wt(3); check("clear pin released", q[3], 1);
    $display("preset clear test done");
  endtask
  // cell 5 lends to cell 6; cell 7 tops chain one, cell 8 starts chain two
  task t_expand;
    wb(1, 12'h114, 32'h8000);
    wb(1, 12'h118, 32'h80);
    wb(1, 12'h4b4, 32'h4);
    wb(1, 12'h11c, 32'h8000);
    wb(1, 12'h120, 32'h8180);
    wb(1, 12'h124, 32'h80);
    ded <= 4'h3;
    pin1;
    check("borrow off q6", q[6], 0);
    check("chain top q8", q[8], 0);
    check("chain bottom q9", q[9], 1);
    ded <= 4'h7;
    pin1;
    check("borrow on q6", q[6], 1);
    check("chain split q8", q[8], 0);
    $display("expander test done");
  endtask
  // reset in mid-run clears registers and configuration
  task t_rerun;
    reset_n_i <= 0;
    wt(1);
    check("reset q", q, 0);
    reset_n_i <= 1;
    wt(3);
    wb(0, 12'h114, 0);
    check("config after reset", rd, 0);
    wb(0, 12'h000, 0);
    check("nets after reset", rd, 32'h4);
    $display("mid-run reset test done");
  endtask
  // hang guard, far above the hundred or so cycles the tests need
  always @(posedge clk_i) begin
    tick++;
    if (tick > 3000) begin
      fail_count++;
      stop_test;
    end
  end
  initial begin
    wt(2);
    reset_n_i <= 1;
    wt(3);
    t_reset;
    t_global;
    t_invert;
    t_array;
    t_prsclr;
    t_expand;
    t_rerun;
    stop_test;
  end
endmodule // mre_lab_tb
